// [rtl/rocof_function_block.sv]
// rocof stage blocking, status, event and fault record logic
//
// Summary of operation
// - block input sampled once per program cycle, used for that cycle.
// - block comes from one dedicated input per stage, or from the block and test-block modes for all stages.
// - pick-up without block asserts start and starts delay timing.
// - pick-up with block asserts blocked, nothing further.
// - block after start clears start and runs release timing.
// - blocking gives display pulse and block event with startup frequency.
// - trip and reset delays are definite time only.
// - start, trip, blocked changes make events and fault records.
// - setting selects on, off or both events; others dropped.
// - events carry time stamp and process data.
// - six event codes per stage, 48 codes in all.
// - last twelve fault records kept.
// - record holds time, event, pre-trig and fault values, group.
// - condition reads 0 normal, 1 start, 2 trip, 3 blocked.
// - node behaviour 1..5 readable only when node mode allowed.
// - measured rate readable at 0.001 Hz/s.
// - per-stage measured to pick-up ratio at 0.005 per unit.
// - expected operating time readable at 0.005 s.
// - signed remaining time counts down while timing.
// - 1 ms stamps; instant start and trip share a stamp.
// - eight setting groups, one selected from common source.
`include "rocof_map.svh"
`default_nettype none
module rocof_function_block #(
   parameter int CYCLE_CLKS = `PROG_CYCLE_NS / `CLK_PERIOD_NS,
   parameter int STAMP_CLKS = `STAMP_NS / `CLK_PERIOD_NS
)(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // blocking matrix and pick-up pins
   input wire logic [7:0] BLOCK_IN,
   input wire logic [7:0] PICKUP_IN,
   // measurements and active group
   input wire rocof_pkg::meas_t RATE_IN,
   input wire rocof_pkg::meas_t FREQ_IN,
   input wire logic [2:0] SG_IN,
   // stage outputs
   output logic [7:0] START_OUT,
   output logic [7:0] TRIP_OUT,
   output logic [7:0] BLOCKED_OUT,
   // event buffer and display
   output logic EVT_VALID,
   output rocof_pkg::evt_code_t EVT_CODE,
   output logic [31:0] EVT_TIME,
   output rocof_pkg::meas_t EVT_RATE,
   output rocof_pkg::meas_t EVT_FREQ,
   output logic DISP_NOTE
);
   import rocof_pkg::*;

   typedef struct packed {
      logic [7:0] blk_m1, blk_m2, blk_m3, blk_f;
      logic [7:0] pk_m1, pk_m2, pk_m3, pk_f;
      logic [16:0] cyc_div;
      logic tick;
      logic [14:0] ms_div;
      logic [31:0] stamp, cyc_stamp;
      logic [31:0] ctrl;
      logic [18:0] optime, rsttime;
      logic [3:0] recsel;
      logic [7:0][15:0] pickup, su_freq, ratio;
      stage_state_t [7:0] st;
      logic [7:0][18:0] cnt, rel;
      logic [7:0] so, to, bo;
      logic [47:0] pend;
      logic [`PRE_DEPTH-1:0][15:0] h_rate, h_freq;
      meas_t c_rate, c_freq, p_rate, p_freq;
      logic [2:0] c_sg;
      rec_t [11:0] rec;
      logic [3:0] wp, rcount;
      logic [2:0] dv_st;
      logic [4:0] dv_bit;
      logic [24:0] dv_rem;
      logic [23:0] dv_q;
      logic dv_busy;
      logic ev_v;
      evt_code_t ev_c;
      logic [31:0] ev_t;
      meas_t ev_r, ev_f;
      logic disp;
      logic [7:0] a_addr;
      logic a_wr, a_ok, a_pend, hready;
      logic [31:0] hrdata;
   } state_t;

   state_t r, next_r;
   logic [7:0] pk_c, bk_c;
   logic [2:0] mode, stg, kind, idx;
   logic found;
   int j;
   logic [24:0] rem_sh;
   logic [23:0] num;
   logic [31:0] rd;
   rec_t rsel;

   function automatic logic [1:0] cond(input stage_state_t s);
      logic [1:0] c;
      c = 2'h0;
      case (s)
         ST_START: c = 2'h1;
         ST_TRIP: c = 2'h2;
         ST_BLOCK: c = 2'h3;
         default: c = 2'h0;
      endcase
      return c;
   endfunction

   function automatic logic [31:0] remain(input stage_state_t s,
                                          input logic [18:0] c);
      logic [31:0] v;
      v = `REMAIN_IDLE;
      if (s == ST_START)
      begin
         v = {13'h0000, c};
      end
      return v;
   endfunction

   always_comb
   begin
      next_r = r;
      next_r.tick = 1'b0;
      next_r.ev_v = 1'b0;
      next_r.disp = 1'b0;
      mode = r.ctrl[`F_MODE_HI:`F_MODE_LO];
      // three-stage pin synchronisers
      next_r.blk_m1 = BLOCK_IN;
      next_r.blk_m2 = r.blk_m1;
      next_r.blk_m3 = r.blk_m2;
      next_r.blk_f = (r.blk_m2 & r.blk_m3) |
                     (r.blk_f & (r.blk_m2 | r.blk_m3));
      next_r.pk_m1 = PICKUP_IN;
      next_r.pk_m2 = r.pk_m1;
      next_r.pk_m3 = r.pk_m2;
      next_r.pk_f = (r.pk_m2 & r.pk_m3) | (r.pk_f & (r.pk_m2 | r.pk_m3));
      bk_c = r.blk_f | {8{mode == `MODE_BLK || mode == `MODE_TESTBLK}};
      pk_c = r.pk_f & r.ctrl[`F_STEN_HI:`F_STEN_LO] &
             {8{mode != `MODE_OFF}};
      if (r.ms_div == 15'(STAMP_CLKS - 1))
      begin
         next_r.ms_div = 15'h0000;
         next_r.stamp = r.stamp + 32'h0000_0001;
      end
      else
      begin
         next_r.ms_div = r.ms_div + 15'h0001;
      end
      if (r.cyc_div == 17'(CYCLE_CLKS - 1))
      begin
         next_r.cyc_div = 17'h00000;
         next_r.tick = 1'b1;
      end
      else
      begin
         next_r.cyc_div = r.cyc_div + 17'h00001;
      end
      // ratio divider, one stage at a time
      num = 24'(r.c_rate) * `RATIO_SCALE;
      rem_sh = {r.dv_rem[23:0], num[r.dv_bit]};
      if (r.dv_busy)
      begin
         if (rem_sh >= {9'h000, r.pickup[r.dv_st]})
         begin
            next_r.dv_rem = rem_sh - {9'h000, r.pickup[r.dv_st]};
            next_r.dv_q[r.dv_bit] = 1'b1;
         end
         else
         begin
            next_r.dv_rem = rem_sh;
         end
         if (r.dv_bit == 5'h00)
         begin
            next_r.ratio[r.dv_st] = (next_r.dv_q[23:16] != 8'h00) ?
                                    `RATIO_MAX : next_r.dv_q[15:0];
            next_r.dv_bit = `DIV_MSB;
            next_r.dv_rem = 25'h0000000;
            next_r.dv_q = 24'h000000;
            next_r.dv_st = r.dv_st + 3'h1;
            next_r.dv_busy = (r.dv_st != 3'h7);
         end
         else
         begin
            next_r.dv_bit = r.dv_bit - 5'h01;
         end
      end
      // pending event serialiser
      found = 1'b0;
      j = 0;
      for (int k = `EVT_CODES - 1; k >= 0; k--)
      begin
         if (r.pend[k])
         begin
            j = k;
            found = 1'b1;
         end
      end
      stg = 3'(j / `CODES_PER_STAGE);
      kind = 3'(j % `CODES_PER_STAGE);
      if (found)
      begin
         next_r.pend[j] = 1'b0;
         next_r.rec[r.wp] = '{r.cyc_stamp, 6'(j), r.c_sg, r.p_rate,
                              r.p_freq, r.c_rate, r.c_freq};
         next_r.wp = (r.wp == `REC_LAST) ? 4'h0 : r.wp + 4'h1;
         if (r.rcount != `REC_NUM)
         begin
            next_r.rcount = r.rcount + 4'h1;
         end
         if (kind[0] ? r.ctrl[`F_POL_OFF] : r.ctrl[`F_POL_ON])
         begin
            next_r.ev_v = 1'b1;
            next_r.ev_c = 6'(j);
            next_r.ev_t = r.cyc_stamp;
            next_r.ev_r = r.c_rate;
            next_r.ev_f = (kind >= 3'(`EV_BLOCK_ON)) ?
                          r.su_freq[stg] : r.c_freq;
         end
      end
      if (r.tick)
      begin
         next_r.cyc_stamp = r.stamp;
         next_r.c_rate = RATE_IN;
         next_r.c_freq = FREQ_IN;
         next_r.c_sg = SG_IN;
         next_r.p_rate = r.h_rate[`PRE_DEPTH-1];
         next_r.p_freq = r.h_freq[`PRE_DEPTH-1];
         next_r.h_rate[0] = RATE_IN;
         next_r.h_freq[0] = FREQ_IN;
         for (int k = 1; k < `PRE_DEPTH; k++)
         begin
            next_r.h_rate[k] = r.h_rate[k-1];
            next_r.h_freq[k] = r.h_freq[k-1];
         end
         next_r.dv_busy = 1'b1;
         next_r.dv_st = 3'h0;
         next_r.dv_bit = `DIV_MSB;
         next_r.dv_rem = 25'h0000000;
         next_r.dv_q = 24'h000000;
         for (int i = 0; i < `STAGES; i++)
         begin
            // sampled block used for the cycle
            case (r.st[i])
               ST_NORMAL:
               begin
                  if (pk_c[i])
                  begin
                     next_r.su_freq[i] = FREQ_IN;
                     if (bk_c[i])
                     begin
                        next_r.st[i] = ST_BLOCK;
                        next_r.bo[i] = 1'b1;
                     end
                     else
                     begin
                        next_r.so[i] = 1'b1;
                        next_r.cnt[i] = r.optime;
                        next_r.st[i] = ST_START;
                        if (r.optime == 19'h00000)
                        begin
                           next_r.st[i] = ST_TRIP;
                           next_r.to[i] = 1'b1;
                        end
                     end
                  end
               end
               ST_START:
               begin
                  if (bk_c[i] || !pk_c[i])
                  begin
                     next_r.so[i] = 1'b0;
                     next_r.rel[i] = r.rsttime;
                     next_r.st[i] = ST_RELEASE;
                     if (r.rsttime == 19'h00000)
                     begin
                        next_r.st[i] = ST_NORMAL;
                        next_r.cnt[i] = 19'h00000;
                     end
                  end
                  else if (r.cnt[i] <= 19'h00001)
                  begin
                     next_r.cnt[i] = 19'h00000;
                     next_r.to[i] = 1'b1;
                     next_r.st[i] = ST_TRIP;
                  end
                  else
                  begin
                     next_r.cnt[i] = r.cnt[i] - 19'h00001;
                  end
               end
               ST_TRIP:
               begin
                  if (bk_c[i] || !pk_c[i])
                  begin
                     next_r.so[i] = 1'b0;
                     next_r.to[i] = 1'b0;
                     next_r.st[i] = ST_NORMAL;
                  end
               end
               ST_BLOCK:
               begin
                  if (!bk_c[i] || !pk_c[i])
                  begin
                     next_r.bo[i] = 1'b0;
                     next_r.st[i] = ST_NORMAL;
                  end
               end
               ST_RELEASE:
               begin
                  if (pk_c[i] && !bk_c[i])
                  begin
                     next_r.so[i] = 1'b1;
                     next_r.st[i] = ST_START;
                  end
                  else if (r.rel[i] <= 19'h00001)
                  begin
                     next_r.cnt[i] = 19'h00000;
                     next_r.st[i] = ST_NORMAL;
                  end
                  else
                  begin
                     next_r.rel[i] = r.rel[i] - 19'h00001;
                  end
               end
               default:
               begin
                  next_r.st[i] = ST_NORMAL;
                  next_r.so[i] = 1'b0;
                  next_r.to[i] = 1'b0;
                  next_r.bo[i] = 1'b0;
               end
            endcase
            // six codes per stage; set wins over clear
            next_r.pend[i*`CODES_PER_STAGE+`EV_START_ON] |=
               next_r.so[i] & ~r.so[i];
            next_r.pend[i*`CODES_PER_STAGE+`EV_START_OFF] |=
               ~next_r.so[i] & r.so[i];
            next_r.pend[i*`CODES_PER_STAGE+`EV_TRIP_ON] |=
               next_r.to[i] & ~r.to[i];
            next_r.pend[i*`CODES_PER_STAGE+`EV_TRIP_OFF] |=
               ~next_r.to[i] & r.to[i];
            next_r.pend[i*`CODES_PER_STAGE+`EV_BLOCK_ON] |=
               next_r.bo[i] & ~r.bo[i];
            next_r.pend[i*`CODES_PER_STAGE+`EV_BLOCK_OFF] |=
               ~next_r.bo[i] & r.bo[i];
         end
         next_r.disp = |(next_r.bo & ~r.bo);
      end
      // register read mux
      rsel = (r.recsel < `REC_NUM) ? r.rec[r.recsel] : '0;
      idx = r.a_addr[4:2];
      rd = 32'h0000_0000;
      if (r.a_ok)
      begin
         case (r.a_addr)
            `A_CTRL: rd = r.ctrl;
            `A_OPTIME: rd = {13'h0000, r.optime};
            `A_RSTTIME: rd = {13'h0000, r.rsttime};
            `A_RECSEL: rd = {28'h0000000, r.recsel};
            `A_COND:
            begin
               for (int i = 0; i < `STAGES; i++)
               begin
                  rd[2*i+:2] = cond(r.st[i]);
               end
            end
            `A_BEHAV: rd = r.ctrl[`F_MODE_EN] ? {29'h0, mode} : 32'h0;
            `A_RATE: rd = {16'h0000, r.c_rate};
            `A_EXPECT: rd = {13'h0000, r.optime};
            `A_REC_TIME: rd = rsel.stamp;
            `A_REC_INFO:
            begin
               rd = {12'h000, r.rcount, 5'h00, rsel.sg, 2'h0, rsel.code};
            end
            `A_REC_PRE: rd = {rsel.pre_rate, rsel.pre_freq};
            `A_REC_FLT: rd = {rsel.flt_rate, rsel.flt_freq};
            default:
            begin
               if (r.a_addr[7:5] == `A_PICKUP_BLK && !r.a_addr[1])
               begin
                  rd = {16'h0000, r.pickup[idx]};
               end
               else if (r.a_addr[7:5] == `A_REMAIN_BLK)
               begin
                  rd = remain(r.st[idx], r.cnt[idx]);
               end
               else if (r.a_addr[7:5] == `A_RATIO_BLK)
               begin
                  rd = {16'h0000, r.ratio[idx]};
               end
            end
         endcase
      end
      // ahb-lite: one wait state per transfer
      if (r.a_pend)
      begin
         next_r.a_pend = 1'b0;
         next_r.hready = 1'b1;
         if (!r.a_wr)
         begin
            next_r.hrdata = rd;
         end
         else if (r.a_ok)
         begin
            case (r.a_addr)
               `A_CTRL: next_r.ctrl = HWDATA;
               `A_OPTIME: next_r.optime = HWDATA[18:0];
               `A_RSTTIME: next_r.rsttime = HWDATA[18:0];
               `A_RECSEL: next_r.recsel = HWDATA[3:0];
               default:
               begin
                  if (r.a_addr[7:5] == `A_PICKUP_BLK)
                  begin
                     next_r.pickup[idx] = HWDATA[15:0];
                  end
               end
            endcase
         end
      end
      else if (HSEL && HREADY && HTRANS[1])
      begin
         next_r.a_addr = HADDR[7:0];
         next_r.a_wr = HWRITE;
         next_r.a_ok = (HADDR[31:8] == 24'h000000) && (HSIZE == 3'h2);
         next_r.a_pend = 1'b1;
         next_r.hready = 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         r <= '0;
         r.ctrl <= `CTRL_RST;
         r.optime <= `OPTIME_RST;
         r.pickup <= {8{`PICKUP_RST}};
         r.dv_bit <= `DIV_MSB;
         r.hready <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign HRDATA = r.hrdata;
   assign HREADYOUT = r.hready;
   assign HRESP = 1'b0;
   assign START_OUT = r.so;
   assign TRIP_OUT = r.to;
   assign BLOCKED_OUT = r.bo;
   assign EVT_VALID = r.ev_v;
   assign EVT_CODE = r.ev_c;
   assign EVT_TIME = r.ev_t;
   assign EVT_RATE = r.ev_r;
   assign EVT_FREQ = r.ev_f;
   assign DISP_NOTE = r.disp;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   property p_cycle_only;
      !r.tick |=> $stable({r.so, r.to, r.bo});
   endproperty
   a_cycle_only: assert property (p_cycle_only)
      else $error("stage outputs moved outside a program cycle");

   property p_start;
      r.tick && r.st[0] == ST_NORMAL && pk_c[0] && !bk_c[0]
         |=> r.so[0] && !r.bo[0];
   endproperty
   a_start: assert property (p_start)
      else $error("pick-up without block did not start");

   property p_blocked;
      r.tick && r.st[0] == ST_NORMAL && pk_c[0] && bk_c[0]
         |=> r.bo[0] && !r.so[0] && !r.to[0];
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("pick-up under block did not give blocked");

   property p_release;
      r.tick && r.st[0] == ST_START && bk_c[0]
         |=> !r.so[0] && !r.to[0] && r.st[0] != ST_TRIP;
   endproperty
   a_release: assert property (p_release)
      else $error("late block did not release start");

   property p_trip_event;
      $rose(r.to[2]) && r.ctrl[`F_POL_ON]
         |-> ##[1:60] (r.ev_v && r.ev_c == 6'h0E);
   endproperty
   a_trip_event: assert property (p_trip_event)
      else $error("trip on event missing");

   property p_polarity;
      r.ev_v |-> (r.ev_c[0] ? r.ctrl[`F_POL_OFF] : r.ctrl[`F_POL_ON]);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("event of unselected polarity emitted");

   property p_records;
      r.rcount <= `REC_NUM && r.wp < `REC_NUM;
   endproperty
   a_records: assert property (p_records)
      else $error("fault record index out of range");

   property p_countdown;
      r.tick && r.st[0] == ST_START && pk_c[0] && !bk_c[0] && r.cnt[0] > 1
         |=> r.cnt[0] == $past(r.cnt[0]) - 19'h00001;
   endproperty
   a_countdown: assert property (p_countdown)
      else $error("remaining time did not count down");

   property p_sentinel;
      r.a_pend && !r.a_wr && r.a_ok && r.a_addr[7:5] == `A_REMAIN_BLK &&
         r.st[r.a_addr[4:2]] != ST_START |=> r.hrdata == `REMAIN_IDLE;
   endproperty
   a_sentinel: assert property (p_sentinel)
      else $error("idle remaining time not sentinel");

   c_trip: cover property ($rose(r.to[2]));
   c_block: cover property ($rose(r.bo[0]));
   c_release: cover property (r.st[0] == ST_RELEASE);
   c_event: cover property (r.ev_v && r.rcount == `REC_NUM);
endmodule
`default_nettype wire

// [rtl/rocof_map.svh]
// register offsets, field positions, reset values and timing of the block
`ifndef ROCOF_MAP_SVH
`define ROCOF_MAP_SVH
`define CLK_PERIOD_NS 50
`define PROG_CYCLE_NS 5000000
`define STAMP_NS 1000000
`define PROG_CYCLE_MS 5
`define PRE_TRIG_MS 20
`define PRE_DEPTH (`PRE_TRIG_MS / `PROG_CYCLE_MS)
`define BLOCK_LEAD_MS 5
`define STAGES 8
`define CODES_PER_STAGE 6
`define EVT_CODES 48
`define REC_LAST 4'hB
`define REC_NUM 4'hC
`define EV_START_ON 0
`define EV_START_OFF 1
`define EV_TRIP_ON 2
`define EV_TRIP_OFF 3
`define EV_BLOCK_ON 4
`define EV_BLOCK_OFF 5
`define A_CTRL 8'h00
`define A_OPTIME 8'h04
`define A_RSTTIME 8'h08
`define A_RECSEL 8'h0C
`define A_COND 8'h10
`define A_BEHAV 8'h14
`define A_RATE 8'h18
`define A_EXPECT 8'h1C
`define A_REC_TIME 8'h20
`define A_REC_INFO 8'h24
`define A_REC_PRE 8'h28
`define A_REC_FLT 8'h2C
`define A_PICKUP_BLK 3'h2
`define A_REMAIN_BLK 3'h3
`define A_RATIO_BLK 3'h4
`define F_POL_ON 0
`define F_POL_OFF 1
`define F_MODE_EN 2
`define F_MODE_HI 6
`define F_MODE_LO 4
`define F_STEN_HI 15
`define F_STEN_LO 8
`define CTRL_RST 32'h0000_0013
`define OPTIME_RST 19'h00014
`define PICKUP_RST 16'h00C8
`define REMAIN_IDLE 32'h8000_0000
`define RATIO_SCALE 24'h0000C8
`define RATIO_MAX 16'hFFFF
`define DIV_MSB 5'h17
`define MODE_BLK 3'h2
`define MODE_TESTBLK 3'h4
`define MODE_OFF 3'h5
`endif

// [rtl/rocof_pkg.sv]
// shared types of the rocof stage logic
`default_nettype none
package rocof_pkg;
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_START,
      ST_TRIP,
      ST_BLOCK,
      ST_RELEASE
   } stage_state_t;
   typedef logic [5:0] evt_code_t;
   typedef logic [15:0] meas_t;
   typedef struct packed {
      logic [31:0] stamp;
      evt_code_t code;
      logic [2:0] sg;
      meas_t pre_rate;
      meas_t pre_freq;
      meas_t flt_rate;
      meas_t flt_freq;
   } rec_t;
endpackage
`default_nettype wire

// [verif/evt_buffer_model.sv]
// event buffer and display model that logs every code seen
`default_nettype none
module evt_buffer_model
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // event port of the block
   input wire logic valid,
   input wire rocof_pkg::evt_code_t code,
   input wire logic note
);
   timeunit 1ns;
   timeprecision 1ps;
   import rocof_pkg::*;
   logic [47:0] seen;
   logic note_seen;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         seen <= '0;
         note_seen <= 1'b0;
      end
      else
      begin
         if (valid)
            seen[code] <= 1'b1;
         if (note)
            note_seen <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [verif/rocof_function_block_tb.sv]
// testbench for the rocof stage block
`default_nettype none
module rocof_function_block_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CYC = 200;
   logic clk, rst, hsel, hwrite, hready, hresp, evt_valid, note;
   logic [31:0] haddr, hwdata, hrdata, rd, evt_time;
   logic [1:0] htrans;
   logic [2:0] hsize, sg;
   logic [7:0] blk, pick, start_o, trip_o, blocked_o;
   logic [15:0] rate, freq, evt_rate, evt_freq;
   logic [5:0] evt_code;
   int err_total, total_checks;
   rocof_function_block #(.CYCLE_CLKS(CYC), .STAMP_CLKS(50)) uut (
      .CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP(hresp), .BLOCK_IN(blk), .PICKUP_IN(pick), .RATE_IN(rate),
      .FREQ_IN(freq), .SG_IN(sg), .START_OUT(start_o), .TRIP_OUT(trip_o),
      .BLOCKED_OUT(blocked_o), .EVT_VALID(evt_valid), .EVT_CODE(evt_code),
      .EVT_TIME(evt_time), .EVT_RATE(evt_rate), .EVT_FREQ(evt_freq),
      .DISP_NOTE(note));
   evt_buffer_model ev (.clk(clk), .rst(rst), .valid(evt_valid),
      .code(evt_code), .note(note));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   // single word transfer, one wait honoured
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0, rd);
      chk(rd, exp);
   endtask
   task automatic ticks(input int n);
      repeat (n * CYC) @(posedge clk);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
   initial
   begin
      {rst, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      {blk, pick} = '0;
      rst = 1'b1;
      rate = 16'h0100;
      freq = 16'hC350;
      sg = 3'h5;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_chk(32'h00, 32'h13);
      rd_chk(32'h04, 32'h14);
      rd_chk(32'h40, 32'hC8);
      rd_chk(32'h60, 32'h8000_0000);
      rd_chk(32'h10, 32'h0);
      rd_chk(32'hFC, 32'h0);
      chk(hresp, 1'b0);
      bus(32'h00, 1'b1, 32'h0000_FF15, rd);
      rd_chk(32'h14, 32'h1);
      $display("reset and map test done");
      pick[0] <= 1'b1;
      ticks(3);
      chk(start_o, 8'h01);
      rd_chk(32'h10, 32'h1);
      rd_chk(32'h18, 32'h100);
      rd_chk(32'h80, 32'h100);
      rd_chk(32'h2C, 32'h0100_C350);
      // block leads trip by far more than 5 ms
      blk[0] <= 1'b1;
      ticks(3);
      chk(start_o, 8'h00);
      chk(blocked_o, 8'h01);
      chk(ev.seen[1:0], 2'b01);
      {pick[0], blk[0]} <= 2'b00;
      $display("start and release test done");
      blk[1] <= 1'b1;
      ticks(1);
      pick[1] <= 1'b1;
      ticks(3);
      chk(blocked_o, 8'h02);
      chk(start_o, 8'h00);
      rd_chk(32'h10, 32'hC);
      chk(ev.seen[10], 1'b1);
      chk(ev.note_seen, 1'b1);
      chk(evt_freq, 16'hC350);
      chk(evt_rate, 16'h0100);
      chk(evt_time, 32'h0000_0020);
      {pick[1], blk[1]} <= 2'b00;
      $display("blocked test done");
      bus(32'h04, 1'b1, 32'h2, rd);
      rd_chk(32'h1C, 32'h2);
      pick[2] <= 1'b1;
      ticks(6);
      chk(trip_o, 8'h04);
      rd_chk(32'h10, 32'h20);
      chk({ev.seen[14], ev.seen[12]}, 2'b11);
      bus(32'h0C, 1'b1, 32'h0, rd);
      bus(32'h24, 1'b0, 32'h0, rd);
      chk(rd & 32'h700, 32'h500);
      pick[2] <= 1'b0;
      ticks(3);
      chk(trip_o, 8'h00);
      chk(ev.seen[15], 1'b0);
      $display("trip test done");
      bus(32'h00, 1'b1, 32'h0000_FF21, rd);
      rd_chk(32'h14, 32'h0);
      pick[3] <= 1'b1;
      ticks(2);
      chk(blocked_o, 8'h08);
      chk(start_o, 8'h00);
      $display("forced block test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
